// ---- hdl/pps_cfg.svh ----
// Register map, field positions and reset values of the port power pin block
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// Register indexes as printed; byte address is four times the index
`define PPS_IDX_DIR 16'h0932
`define PPS_IDX_OUT 16'h0936
`define PPS_IDX_IN 16'h093a
`define PPS_IDX_PU 16'h093e
`define PPS_IDX_SEL1 16'h3c00
`define PPS_ADDR_W 18

// Field positions of the port 1 select register
`define PPS_SEL_SHARED_BIT 7
`define PPS_SEL_DIS_BIT 5
`define PPS_SEL_FIXED_BIT 4
`define PPS_SEL_CODE_HI 3
`define PPS_SEL_CODE_LO 0

// Writable bit masks and reset values
`define PPS_PIN_MASK 8'hfe
`define PPS_SEL_MASK 8'hbf
`define PPS_RST_DIR 8'h00
`define PPS_RST_OUT 8'h00
`define PPS_RST_PU 8'h00
`define PPS_RST_SEL 8'h00

`endif

// ---- hdl/pps_pkg.sv ----
// Types of the port power pin block
`default_nettype none

package pps_pkg;
    typedef enum logic [3:0]
    {
        PPS_SRC_OFF = 4'b0000,
        PPS_SRC_USB2 = 4'b0001,
        PPS_SRC_USB3 = 4'b0010,
        PPS_SRC_EITHER = 4'b0011,
        PPS_SRC_GPIO = 4'b0100
    } pps_source_type;
endpackage

`default_nettype wire

// ---- hdl/pps_port_power.sv ----
// Port power pin control with APB register access
//
// Overview of operation
// RULE_01 - Output register bits 7:1 give data driven on each supply pin.
// RULE_02 - Input register bits 7:1 read the sampled level of each pin.
// RULE_03 - Pull-up register bit N enables pull-up on supply pin N.
// RULE_04 - Select bit 7 picks shared power and over-current pins when set.
// RULE_05 - Select bit 5 marks port 1 permanently disabled.
// RULE_06 - Select bit 4 marks port 1 as having a fixed device.
// RULE_07 - Codes 0000b off, 0001b follow USB2, 0010b follow USB3 power.
// RULE_08 - Code 0011b follows USB2 or USB3, code 0100b follows the GPIO.
// RULE_09 - Software writes only the five defined source codes.
// RULE_10 - Software loads select settings once and leaves them alone.
// RULE_11 - Disable, fixed and shared bits are set before enumeration.
// RULE_12 - Direction bit zero makes a pin input, one makes it output.
// RULE_13 - Output data reaches a pin only while direction selects output.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pps_cfg.svh"

module pps_port_power
(
    input wire logic pclk, // APB clock, 125 MHz
    input wire logic presetn, // Asynchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [7:0] supply_pin_in, // Supply pin input levels
    output logic [7:0] supply_pin_out, // Supply pin output data
    output logic [7:0] supply_pin_oe, // Supply pin output enables
    output logic [7:0] supply_pin_pullup, // Supply pin pull-up enables
    input wire logic usb2_port_power, // USB2 port power request
    input wire logic usb3_port_power, // USB3 port power request
    input wire logic gpio_port_power, // Designated GPIO level
    output logic port1_power_on, // Port 1 power switch control
    output logic port1_shared_pins, // Shared power/over-current pins
    output logic port1_disabled, // Port 1 permanently disabled
    output logic port1_fixed_attachment // Port 1 non-removable device
);

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    logic [7:0] supply_pin_dir_bits;
    logic [7:0] supply_pin_out_bits;
    logic [7:0] supply_pin_pullup_bits;
    logic [7:0] port1_power_source_select;
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] sync_c;
    logic [7:0] port_power_pin_input;
    logic [3:0] supply_source_code;
    logic hit_dir;
    logic hit_out;
    logic hit_in;
    logic hit_pu;
    logic hit_sel;
    logic mapped;
    logic wr_en;
    logic rd_en;
    logic next_power;

    assign hit_dir = paddr[31:0] == 32'(`PPS_IDX_DIR) * 32'h0000_0004;
    assign hit_out = paddr[31:0] == 32'(`PPS_IDX_OUT) * 32'h0000_0004;
    assign hit_in = paddr[31:0] == 32'(`PPS_IDX_IN) * 32'h0000_0004;
    assign hit_pu = paddr[31:0] == 32'(`PPS_IDX_PU) * 32'h0000_0004;
    assign hit_sel = paddr[31:0] == 32'(`PPS_IDX_SEL1) * 32'h0000_0004;
    assign mapped = hit_dir | hit_out | hit_in | hit_pu | hit_sel;
    assign wr_en = psel & penable & pwrite & mapped;
    assign rd_en = psel & ~penable & ~pwrite;

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            supply_pin_dir_bits <= `PPS_RST_DIR;
        else if (wr_en && hit_dir)
            supply_pin_dir_bits <= pwdata[7:0] & `PPS_PIN_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            supply_pin_out_bits <= `PPS_RST_OUT;
        else if (wr_en && hit_out)
            supply_pin_out_bits <= pwdata[7:0] & `PPS_PIN_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            supply_pin_pullup_bits <= `PPS_RST_PU;
        else if (wr_en && hit_pu)
            supply_pin_pullup_bits <= pwdata[7:0] & `PPS_PIN_MASK;
    end

    // Settings are loaded once from configuration; no interlock is built
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port1_power_source_select <= `PPS_RST_SEL;
        else if (wr_en && hit_sel)
            port1_power_source_select <= pwdata[7:0] & `PPS_SEL_MASK;
    end

    // ------------------------------------------------------------
    // Pin input sampling
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
            sync_c <= 8'h00;
        end
        else
        begin
            sync_a <= supply_pin_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // RULE_02 sampled pin levels
    // A bit changes only once the second and third stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_power_pin_input <= 8'h00;
        else
            port_power_pin_input <= ((sync_b & sync_c)
                | (port_power_pin_input & (sync_b | sync_c))) & `PPS_PIN_MASK;
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            // RULE_01 RULE_12 RULE_13 gated pin drive
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    supply_pin_out[gi] <= 1'b0;
                    supply_pin_oe[gi] <= 1'b0;
                end
                else
                begin
                    supply_pin_oe[gi] <= supply_pin_dir_bits[gi];
                    supply_pin_out[gi] <= supply_pin_dir_bits[gi]
                        & supply_pin_out_bits[gi];
                end
            end
            // RULE_03 pull-up enable
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    supply_pin_pullup[gi] <= 1'b0;
                else
                    supply_pin_pullup[gi] <= supply_pin_pullup_bits[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Port 1 power source selection
    // ------------------------------------------------------------
    assign supply_source_code =
        port1_power_source_select[`PPS_SEL_CODE_HI:`PPS_SEL_CODE_LO];

    // RULE_07 RULE_08 source decode
    // Reserved codes keep the port off, the safe choice for a switch
    always_comb
    begin
        case (pps_pkg::pps_source_type'(supply_source_code))
            pps_pkg::PPS_SRC_OFF: next_power = 1'b0;
            pps_pkg::PPS_SRC_USB2: next_power = usb2_port_power;
            pps_pkg::PPS_SRC_USB3: next_power = usb3_port_power;
            pps_pkg::PPS_SRC_EITHER: next_power = usb2_port_power | usb3_port_power;
            pps_pkg::PPS_SRC_GPIO: next_power = gpio_port_power;
            default: next_power = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port1_power_on <= 1'b0;
        else
            port1_power_on <= next_power;
    end

    // RULE_04 RULE_05 RULE_06 port 1 flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port1_shared_pins <= 1'b0;
            port1_disabled <= 1'b0;
            port1_fixed_attachment <= 1'b0;
        end
        else
        begin
            port1_shared_pins <= port1_power_source_select[`PPS_SEL_SHARED_BIT];
            port1_disabled <= port1_power_source_select[`PPS_SEL_DIS_BIT];
            port1_fixed_attachment <= port1_power_source_select[`PPS_SEL_FIXED_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
        begin
            if (hit_dir)
                prdata <= {24'h00_0000, supply_pin_dir_bits};
            else if (hit_out)
                prdata <= {24'h00_0000, supply_pin_out_bits};
            else if (hit_in)
                prdata <= {24'h00_0000, port_power_pin_input};
            else if (hit_pu)
                prdata <= {24'h00_0000, supply_pin_pullup_bits};
            else if (hit_sel)
                prdata <= {24'h00_0000, port1_power_source_select};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_out_drive;
        @(posedge pclk) disable iff (!presetn)
        ##1 supply_pin_out == ($past(supply_pin_out_bits) & $past(supply_pin_dir_bits));
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("pin data wrong"); // RULE_01

    property p_in_stable;
        @(posedge pclk) disable iff (!presetn)
        (sync_b[1] && sync_c[1]) |=> port_power_pin_input[1];
    endproperty
    a_in_stable: assert property (p_in_stable) else $error("input not taken"); // RULE_02

    property p_pullup;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_pu) |=> ##1 supply_pin_pullup[7:1] == $past(pwdata[7:1], 2);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up wrong"); // RULE_03

    property p_shared;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_sel) |=> ##1 port1_shared_pins == $past(pwdata[7], 2);
    endproperty
    a_shared: assert property (p_shared) else $error("shared bit wrong"); // RULE_04

    property p_disable;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_sel) |=> ##1 port1_disabled == $past(pwdata[5], 2);
    endproperty
    a_disable: assert property (p_disable) else $error("disable bit wrong"); // RULE_05

    property p_fixed;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_sel) |=> ##1 port1_fixed_attachment == $past(pwdata[4], 2);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed bit wrong"); // RULE_06

    property p_src_off;
        @(posedge pclk) disable iff (!presetn)
        (supply_source_code == 4'h0) |=> !port1_power_on;
    endproperty
    a_src_off: assert property (p_src_off) else $error("port on while off"); // RULE_07

    property p_src_either;
        @(posedge pclk) disable iff (!presetn)
        (supply_source_code == 4'h3) |=>
            port1_power_on == ($past(usb2_port_power) | $past(usb3_port_power));
    endproperty
    a_src_either: assert property (p_src_either) else $error("either source wrong"); // RULE_08

    property p_oe_dir;
        @(posedge pclk) disable iff (!presetn)
        !supply_pin_dir_bits[3] |=> !supply_pin_oe[3] && !supply_pin_out[3];
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("input pin driven"); // RULE_12 RULE_13

    property p_oe_follow;
        @(posedge pclk) disable iff (!presetn)
        supply_pin_dir_bits[3] |=> supply_pin_oe[3];
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("output pin not driven"); // RULE_12

    property p_in_clear;
        @(posedge pclk) disable iff (!presetn)
        (!sync_b[2] && !sync_c[2]) |=> !port_power_pin_input[2];
    endproperty
    a_in_clear: assert property (p_in_clear) else $error("input low not taken"); // RULE_02

    property p_src_usb2;
        @(posedge pclk) disable iff (!presetn)
        (supply_source_code == pps_pkg::PPS_SRC_USB2) |=>
            port1_power_on == $past(usb2_port_power);
    endproperty
    a_src_usb2: assert property (p_src_usb2) else $error("usb2 source wrong"); // RULE_07

    property p_src_usb3;
        @(posedge pclk) disable iff (!presetn)
        (supply_source_code == pps_pkg::PPS_SRC_USB3) |=>
            port1_power_on == $past(usb3_port_power);
    endproperty
    a_src_usb3: assert property (p_src_usb3) else $error("usb3 source wrong"); // RULE_07

    property p_src_gpio;
        @(posedge pclk) disable iff (!presetn)
        (supply_source_code == pps_pkg::PPS_SRC_GPIO) |=>
            port1_power_on == $past(gpio_port_power);
    endproperty
    a_src_gpio: assert property (p_src_gpio) else $error("gpio source wrong"); // RULE_08

    property p_out_readback;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && hit_out) |=> prdata[7:0] == $past(supply_pin_out_bits);
    endproperty
    a_out_readback: assert property (p_out_readback) else $error("output readback wrong"); // RULE_01

endmodule
`default_nettype wire

// ---- bench/pps_pad_model.sv ----
// Model of the external supply switch pads on the port power pins
`timescale 1ns/1ps
`default_nettype none

module pps_pad_model
(
    input wire logic pclk, // Clock for the floating pattern
    input wire logic [7:0] pin_out, // Device output data
    input wire logic [7:0] pin_oe, // Device output enables
    input wire logic [7:0] pin_pullup, // Device pull-up enables
    input wire logic [7:0] ext_en, // External switch drives the pad
    input wire logic [7:0] ext_level, // External switch level
    output logic [7:0] pad_level // Resolved pad level
);
    logic [7:0] float_level = 8'h00;

    // Undriven pads toggle so a stale level never passes
    always_ff @(posedge pclk)
    begin
        float_level <= ~float_level;
    end

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i])
                pad_level[i] = pin_out[i];
            else if (ext_en[i])
                pad_level[i] = ext_level[i];
            else if (pin_pullup[i])
                pad_level[i] = 1'b1;
            else
                pad_level[i] = float_level[i];
        end
    end
endmodule

`default_nettype wire

// ---- bench/port_power_pin_control_bench.sv ----
// Register-level bench of the port power pin block
`timescale 1ns/1ps
`default_nettype none
`include "pps_cfg.svh"

module port_power_pin_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pin_pu;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_level = 8'h00;
    logic usb2 = 1'b0;
    logic usb3 = 1'b0;
    logic gpio = 1'b0;
    logic pwr_on;
    logic shared;
    logic disabled;
    logic fixed;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int checks = 0;
    logic [15:0] idxs [4] = '{`PPS_IDX_DIR, `PPS_IDX_OUT, `PPS_IDX_PU, `PPS_IDX_SEL1};

    pps_port_power dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_pin_in(pin_in), .supply_pin_out(pin_out), .supply_pin_oe(pin_oe),
        .supply_pin_pullup(pin_pu), .usb2_port_power(usb2), .usb3_port_power(usb3),
        .gpio_port_power(gpio), .port1_power_on(pwr_on), .port1_shared_pins(shared),
        .port1_disabled(disabled), .port1_fixed_attachment(fixed)
    );

    pps_pad_model pads
    (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
        .ext_en(ext_en), .ext_level(ext_level), .pad_level(pin_in)
    );

    initial
    begin
        forever #4 pclk = ~pclk;
    end

    function automatic logic [31:0] addr_of(input logic [15:0] idx);
        return {14'h0000, idx, 2'b00};
    endfunction

    function automatic logic src_exp(input logic [3:0] c, input logic [2:0] m);
        case (c)
            pps_pkg::PPS_SRC_USB2: return m[0];
            pps_pkg::PPS_SRC_USB3: return m[1];
            pps_pkg::PPS_SRC_EITHER: return m[0] | m[1];
            pps_pkg::PPS_SRC_GPIO: return m[2];
            default: return 1'b0;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (idxs[i])
        begin
            xfer(1'b0, addr_of(idxs[i]), 32'h0000_0000);
            check(rd, 32'h0000_0000);
        end
        check(32'(pin_oe), 32'h0000_0000);
        xfer(1'b1, addr_of(`PPS_IDX_DIR), 32'h0000_00ff);
        xfer(1'b1, addr_of(`PPS_IDX_OUT), 32'h0000_00ab);
        xfer(1'b1, addr_of(`PPS_IDX_OUT) + 32'h0000_0004, 32'h0000_00ff);
        check(32'(err), 32'h0000_0001);
        xfer(1'b0, addr_of(`PPS_IDX_OUT) + 32'h0000_0004, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        xfer(1'b0, addr_of(`PPS_IDX_OUT), 32'h0000_0000);
        check(rd, 32'h0000_00aa);
        settle(8);
        check(32'(pin_oe), 32'h0000_00fe);
        check(32'(pin_out), 32'h0000_00aa);
        xfer(1'b0, addr_of(`PPS_IDX_IN), 32'h0000_0000);
        check(rd, 32'h0000_00aa);
        xfer(1'b1, addr_of(`PPS_IDX_DIR), 32'h0000_000e);
        settle(2);
        check(32'(pin_out), 32'h0000_000a);
        check(32'(pin_oe), 32'h0000_000e);
        xfer(1'b1, addr_of(`PPS_IDX_DIR), 32'h0000_0000);
        @(posedge pclk);
        ext_en <= 8'hff;
        ext_level <= 8'h5b;
        xfer(1'b1, addr_of(`PPS_IDX_IN), 32'h0000_00ff);
        settle(8);
        xfer(1'b0, addr_of(`PPS_IDX_IN), 32'h0000_0000);
        check(rd, 32'h0000_005a);
        @(posedge pclk);
        ext_en <= 8'h00;
        xfer(1'b1, addr_of(`PPS_IDX_PU), 32'h0000_00ff);
        settle(8);
        check(32'(pin_pu), 32'h0000_00fe);
        xfer(1'b0, addr_of(`PPS_IDX_IN), 32'h0000_0000);
        check(rd, 32'h0000_00fe);
        // flags written before any port traffic
        for (int b = 4; b < 8; b++)
        begin
            xfer(1'b1, addr_of(`PPS_IDX_SEL1), 32'(1) << b);
            settle(2);
            xfer(1'b0, addr_of(`PPS_IDX_SEL1), 32'h0000_0000);
            check(rd, (32'(1) << b) & 32'h0000_00bf);
            check(32'(shared), 32'(b == 7));
            check(32'(disabled), 32'(b == 5));
            check(32'(fixed), 32'(b == 4));
        end
        // only defined codes, one write per code
        for (int c = 0; c < 5; c++)
        begin
            xfer(1'b1, addr_of(`PPS_IDX_SEL1), 32'(c));
            for (int m = 0; m < 8; m++)
            begin
                @(posedge pclk);
                usb2 <= m[0];
                usb3 <= m[1];
                gpio <= m[2];
                settle(3);
                check(32'(pwr_on), 32'(src_exp(4'(c), 3'(m))));
            end
        end
        // Mid-run reset returns every setting to its reset value
        @(posedge pclk);
        presetn <= 1'b0;
        settle(2);
        check(32'(pwr_on), 32'h0000_0000);
        check(32'(pin_pu), 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, addr_of(`PPS_IDX_SEL1), 32'h0000_0000);
        check(rd, 32'h0000_0000);
        end_of_test();
    end

    // Whole run needs well under this many cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        end_of_test();
    end
endmodule

`default_nettype wire
